// file: idscr_map.vh
// register map constants for the identity, scratch and flash count bank
// assumes byte addresses on a 7-bit register port, words on even addresses
`ifndef IDSCR_MAP_VH
`define IDSCR_MAP_VH

`define IDSCR_ADDR_W        7
`define IDSCR_DATA_W        16
`define IDSCR_OFS_YEAR      7'h70
`define IDSCR_OFS_PROD      7'h72
`define IDSCR_OFS_SERIAL    7'h74
`define IDSCR_OFS_SCR1      7'h76
`define IDSCR_OFS_SCR2      7'h78
`define IDSCR_OFS_SCR3      7'h7a
`define IDSCR_OFS_CNT_LO    7'h7c
`define IDSCR_OFS_CNT_HI    7'h7e
`define IDSCR_OFS_CMD       7'h68
`define IDSCR_OFS_DIAG      7'h02
`define IDSCR_CMD_UPD_BIT   3
`define IDSCR_DIAG_FAIL_BIT 2
`define IDSCR_SCR_RESET     16'h0000
`define IDSCR_ZERO16        16'h0000
`define IDSCR_ONE32         32'h00000001

`endif

// file: idscr_flash_counter.v
// 32-bit counter of flash write cycles, split into two read words
// assumes a one-cycle pulse per completed flash write, same clock
`timescale 1ns/10ps
`include "idscr_map.vh"

module idscr_flash_counter #(
  parameter CNT_W = 32
) (
  // clock and control
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             clk_en,
  // event and preset
  input  wire             write_pulse,
  input  wire [CNT_W-1:0] preset_value,
  input  wire             preset_load,
  // count
  output reg  [CNT_W-1:0] count_reg
);

  // preset models the value restored from flash at power up
  always @(posedge mclk) begin
    if (!reset_n) begin
      count_reg <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      if (preset_load) begin
        count_reg <= preset_value;
      end else if (write_pulse) begin
        count_reg <= count_reg + `IDSCR_ONE32;
      end
    end
  end

endmodule // idscr_flash_counter

// file: idscr_regs.v
// identity, scratch and flash write count register bank
// assumes a serial port front end that hands over whole 16-bit word
// accesses on byte addresses; flash engine lives outside this bank
//
// Function
// - year word reads factory year in BCD
// - product word reads fixed product identifier
// - serial word reads lot serial, unwritable
// - three scratch words written and read freely
// - 32-bit counter counts each flash write
// - lower count word shows counter bits 15:0
// - upper count word shows counter bits 31:16
// - command bit 3 backs up, failure flagged
`timescale 1ns/10ps
`include "idscr_map.vh"

module idscr_regs #(
  parameter [15:0] PROD_IDENT  = 16'h1234, // arbitrary value
  parameter [15:0] CONFIG_YEAR = 16'h2000, // arbitrary value
  parameter [15:0] LOT_SERIAL  = 16'h0001  // arbitrary value
) (
  // clock and control
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        clk_en,
  // register port from serial front end
  input  wire [6:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // flash engine side
  output wire        flash_update_req,
  input  wire        flash_done,
  input  wire        flash_fail,
  input  wire [47:0] flash_scratch_in,
  input  wire [31:0] flash_count_in,
  input  wire        flash_restore,
  output wire [47:0] flash_scratch_out,
  // diagnostic view
  output wire        update_fail
);

  reg  [15:0] scr_reg [0:2];
  reg         upd_pend_reg;
  reg         fail_reg;
  wire [31:0] count;
  wire [2:0]  scr_hit;
  reg  [15:0] rdata_next;

  // decode of scratch writes, one per word
  assign scr_hit[0] = reg_addr == `IDSCR_OFS_SCR1;
  assign scr_hit[1] = reg_addr == `IDSCR_OFS_SCR2;
  assign scr_hit[2] = reg_addr == `IDSCR_OFS_SCR3;

  // scratch words; writes elsewhere fall through untouched
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_scr
      always @(posedge mclk) begin
        if (!reset_n) begin
          scr_reg[gi] <= `IDSCR_SCR_RESET;
        end else if (clk_en) begin
          if (reg_wr && scr_hit[gi]) begin
            scr_reg[gi] <= reg_wdata;
          end else if (flash_restore) begin
            scr_reg[gi] <= flash_scratch_in[gi*16 +: 16];
          end
        end
      end
      assign flash_scratch_out[gi*16 +: 16] = scr_reg[gi];
    end
  endgenerate

  // update command held until the flash engine finishes; a new
  // command landing on the done cycle keeps the request alive
  always @(posedge mclk) begin
    if (!reset_n) begin
      upd_pend_reg <= 1'b0;
      fail_reg     <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `IDSCR_OFS_CMD &&
          reg_wdata[`IDSCR_CMD_UPD_BIT]) begin
        upd_pend_reg <= 1'b1;
      end else if (flash_done) begin
        upd_pend_reg <= 1'b0;
      end
      if (flash_done && upd_pend_reg) begin
        fail_reg <= flash_fail;
      end
    end
  end

  assign flash_update_req = upd_pend_reg;
  assign update_fail      = fail_reg;

  idscr_flash_counter #(
    .CNT_W (32)
  ) u_cnt (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .write_pulse  (flash_done),
    .preset_value (flash_count_in),
    .preset_load  (flash_restore),
    .count_reg    (count)
  );

  // read mux; read-only words have no write path at all
  always @* begin
    case (reg_addr)
      `IDSCR_OFS_YEAR:   rdata_next = CONFIG_YEAR;
      `IDSCR_OFS_PROD:   rdata_next = PROD_IDENT;
      `IDSCR_OFS_SERIAL: rdata_next = LOT_SERIAL;
      `IDSCR_OFS_SCR1:   rdata_next = scr_reg[0];
      `IDSCR_OFS_SCR2:   rdata_next = scr_reg[1];
      `IDSCR_OFS_SCR3:   rdata_next = scr_reg[2];
      `IDSCR_OFS_CNT_LO: rdata_next = count[15:0];
      `IDSCR_OFS_CNT_HI: rdata_next = count[31:16];
      `IDSCR_OFS_DIAG:   rdata_next = `IDSCR_ZERO16;
      default:           rdata_next = `IDSCR_ZERO16;
    endcase
    // failure flag placed by its named bit, not by a bare position
    if (reg_addr == `IDSCR_OFS_DIAG) begin
      rdata_next[`IDSCR_DIAG_FAIL_BIT] = fail_reg;
    end
  end

  // registered read data, one cycle after the strobe
  always @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata  <= `IDSCR_ZERO16;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule // idscr_regs

// file: idscr_flash_model.sv
// flash engine model answering update requests
// assumes each request holds until its done pulse
`timescale 1ns/10ps
module idscr_flash_model (
  // clock and reset
  input  wire       mclk,
  input  wire       reset_n,
  // update handshake
  input  wire       flash_update_req,
  input  wire [3:0] wait_cyc,
  input  wire       fail_in,
  output reg        flash_done,
  output wire       flash_fail
);
  reg [3:0] cnt_reg;
  // one done pulse per request, wait_cyc cycles late
  always @(posedge mclk) begin
    flash_done <= reset_n & flash_update_req & ~flash_done
                  & (cnt_reg == wait_cyc);
    cnt_reg <= (!reset_n || !flash_update_req || flash_done) ? 4'h0
               : cnt_reg + 4'h1;
  end
  // fail level only valid with done, inverted otherwise
  assign flash_fail = flash_done ? fail_in : ~fail_in;
endmodule // idscr_flash_model

// file: idscr_regs_checker.sv
// port assertions for the register bank
// assumes clk_en high and default identity words
`timescale 1ns/10ps
module idscr_chk (
  input wire logic        mclk, reset_n, reg_wr, reg_rd, reg_rvalid,
  input wire logic        flash_update_req, flash_done, flash_fail,
  input wire logic        update_fail,
  input wire logic [6:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata
);
  wire cmd = reg_wr & reg_addr == 7'h68 & reg_wdata[3]; // update command
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("rvalid");
  a_year_word: assert property (reg_rd && reg_addr == 7'h70 |=>
    reg_rdata == 16'h2000) else $error("year");
  a_prod_word: assert property (reg_rd && reg_addr == 7'h72 |=>
    reg_rdata == 16'h1234) else $error("product");
  a_serial_word: assert property (reg_rd && reg_addr == 7'h74 |=>
    reg_rdata == 16'h0001) else $error("serial");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata");
  a_update_start: assert property (cmd |=> flash_update_req)
    else $error("req");
  a_update_end: assert property (flash_done && !cmd |=>
    !flash_update_req) else $error("req end");
  a_fail_flag: assert property (flash_done |=>
    update_fail == $past(flash_fail)) else $error("fail");
  c_update: cover property (cmd);
  c_fail: cover property (flash_done && flash_fail);
  c_upper: cover property (reg_rd && reg_addr == 7'h7e);
endmodule // idscr_chk
bind idscr_regs idscr_chk idscr_chk_i (.*);

// file: idscr_regs_bench.sv
// bench for the identity, scratch and flash count bank
// assumes flash model and checker compiled first
`timescale 1ns/10ps
module idscr_regs_bench;
  logic        mclk, reset_n, reg_wr, reg_rd, reg_rvalid, flash_done;
  logic        flash_fail, fail_in, flash_restore, flash_update_req;
  logic        update_fail, clk_en;
  logic [47:0] scr_out;
  logic [3:0]  wait_cyc;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int          error_cnt, n_compared, i;
  logic [6:0]  ro_a[5] = '{7'h70, 7'h72, 7'h74, 7'h7c, 7'h7e};
  logic [15:0] ro_v[5] = '{16'h2000, 16'h1234, 16'h0001, 16'h0, 16'h0};
  idscr_regs idscr_regs_i (.*, .clk_en(clk_en), .flash_scratch_out(scr_out),
    .flash_scratch_in(48'h3333_2222_1111), .flash_count_in(32'hfffe));
  idscr_flash_model idscr_flash_model_i (.*);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input [6:0] a, input [16:0] e, s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED word %h exp %h got %h", a, e, s);
    end
  endtask
  task wr(input [6:0] a, input [15:0] d);
    @(posedge mclk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge mclk);
    #1 reg_wr = 1'b0;
  endtask
  task rd(input [6:0] a, input [15:0] e);
    @(posedge mclk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    chk(a, {1'b1, e}, {reg_rvalid, reg_rdata});
  endtask
  // one update, then fail flag and both count words
  task upd(input f, input [3:0] w, input [15:0] lo, hi);
    {fail_in, wait_cyc} = {f, w};
    wr(7'h68, 16'h0008);
    for (i = 0; i < 40 && flash_update_req !== 1'b0; i++) @(posedge mclk) #1;
    chk(7'h02, {16'h0, f}, {flash_update_req, 15'h0, update_fail});
    rd(7'h02, {13'h0, f, 2'h0});
    rd(7'h7c, lo);
    rd(7'h7e, hi);
  endtask
  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog at 2000 cycles, far beyond the hundred or so cycles needed
  initial begin
    #8000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, flash_restore, reg_addr, reg_wdata} = '0;
    {fail_in, wait_cyc} = '0;
    clk_en = 1'b1;
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b1;
    for (i = 0; i < 5; i++) wr(ro_a[i], 16'hffff);
    for (i = 0; i < 5; i++) rd(ro_a[i], ro_v[i]);
    for (i = 0; i < 3; i++) wr(7'h76 + 2 * i, 16'h1357 * (i + 1));
    for (i = 0; i < 3; i++) rd(7'h76 + 2 * i, 16'h1357 * (i + 1));
    for (i = 0; i < 3; i++) chk(7'h76 + 2 * i, {1'b0, 16'h1357 * (i + 1)},
      {1'b0, scr_out[i*16 +: 16]});
    // frozen clock enable must swallow a scratch write
    clk_en = 1'b0;
    wr(7'h76, 16'hdead);
    clk_en = 1'b1;
    rd(7'h76, 16'h1357);
    rd(7'h40, 16'h0000);
    flash_restore = 1'b1;
    @(posedge mclk);
    #1 flash_restore = 1'b0;
    rd(7'h7a, 16'h3333);
    upd(1'b1, 4'h0, 16'hffff, 16'h0000);
    upd(1'b0, 4'h9, 16'h0000, 16'h0001);
    give_verdict;
  end
endmodule // idscr_regs_bench
